/* File: dmc_aux_ram.sv */
// Purpose: On-chip auxiliary data RAM
// Assumes: One access per cycle, read data one cycle after rd_en
// Notes:   Read data held in a register until the next read
`timescale 1ns/100ps
`default_nettype none
module dmc_aux_ram #(
  parameter int DEPTH  = 1024,
  parameter int ADDR_W = 10
) (
  // Clock
  input wire logic ref_clk,
  // Access port
  dmc_ram_if.mem   ram
);

  logic [7:0] store [DEPTH];

  // Write and registered read; no reset so the array maps to block RAM
  always_ff @(posedge ref_clk) begin
    if (ram.wr_en) begin
      store[ram.addr] <= ram.wdata;
    end
    if (ram.rd_en) begin
      ram.rdata <= store[ram.addr];
    end
  end

endmodule
`default_nettype wire

/* File: dmc_data_memory_control.sv */
// Purpose: Special function registers steering data memory access, plus the MOVX sequencer
// Assumes: CPU core drives the register port and access requests synchronous to ref_clk
// Notes:   External bus timing is stretched by the bus stretch register
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defines.svh"
module dmc_data_memory_control
  import dmc_pkg::*;
#(
  parameter int RAM_DEPTH = 1024,
  parameter int RAM_AW    = 10
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr_en,
  input  wire logic        sfr_rd_en,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  // Core flag updates
  input  wire logic        flag_wr_en,
  input  wire logic        carry_in,
  input  wire logic        half_carry_in,
  input  wire logic        overflow_in,
  input  wire logic [7:0]  acc_value,
  input  wire logic        ptr_inc,
  // Working register addressing
  input  wire logic [2:0]  reg_index,
  output logic      [7:0]  bank_addr,
  // Data pointer view
  output logic      [15:0] data_pointer,
  // Move-external requests
  input  wire logic        xreq,
  input  wire logic        xwrite,
  input  wire logic        xuse_ri,
  input  wire logic [7:0]  xri_addr,
  input  wire logic [7:0]  xpage_hi,
  input  wire logic [7:0]  xwdata,
  output logic             xready,
  output logic             xack,
  output logic      [7:0]  xrdata,
  // External bus pins
  output var  logic [7:0]  ext_addr_hi,
  input  wire logic [7:0]  ext_ad_in,
  output var  logic [7:0]  ext_ad_out,
  output var  logic        ext_ad_oe_n,
  output var  logic        ext_latch,
  output var  logic        ext_wr_n,
  output var  logic        ext_rd_n,
  // Clock enables to timers and serial port
  input  wire logic        timer_b_overflow,
  output logic             timer_a_tick,
  output logic             timer_b_tick,
  output logic             shift_tick,
  output logic             baud_gen_tick,
  output logic             serial_rate_tick,
  output logic             serial_pin_relocate
);

  // Register state
  logic [7:0]    aux_control;
  logic [7:0]    aux_control_two;
  logic [7:0]    external_bus_stretch;
  logic [7:0]    status_hold;
  logic [15:0]   pointer_zero;
  logic [15:0]   pointer_one;
  logic [3:0]    div_count;
  logic          div_phase;
  dmc_state_type state;
  dmc_state_type next_state;
  logic [2:0]    stretch_count;
  logic [2:0]    next_stretch_count;
  logic [15:0]   xfer_addr;
  logic          xfer_write;
  logic [7:0]    xfer_wdata;
  logic [7:0]    ext_rdata;
  logic          last_internal;

  dmc_ram_if #(.ADDR_W(RAM_AW)) ram ();

  dmc_aux_ram #(
    .DEPTH  (RAM_DEPTH),
    .ADDR_W (RAM_AW)
  ) u_aux_ram (
    .ref_clk (ref_clk),
    .ram     (ram)
  );

  // Pick the fast rate or the divided tick
  function automatic logic pick_rate(input logic fast, input logic fast_tick, input logic slow_tick);
    pick_rate = fast ? fast_tick : slow_tick;
  endfunction

  // Register decode
  wire hit_aux     = sfr_addr == `DMC_ADDR_AUX_CONTROL;
  wire hit_aux_two = sfr_addr == `DMC_ADDR_AUX_CONTROL_TWO;
  wire hit_stretch = sfr_addr == `DMC_ADDR_BUS_STRETCH;
  wire hit_status  = sfr_addr == `DMC_ADDR_STATUS_WORD;
  wire hit_ptr_lo  = sfr_addr == `DMC_ADDR_PTR_LOW;
  wire hit_ptr_hi  = sfr_addr == `DMC_ADDR_PTR_HIGH;

  // Field views
  wire       pointer_select   = aux_control_two[`DMC_AC2_POINTER_SELECT];
  wire       aux_ram_disable  = aux_control[`DMC_AC_AUX_RAM_DISABLE];
  wire       timer_a_prescale = aux_control[`DMC_AC_TIMER_A_PRESCALE];
  wire       timer_b_prescale = aux_control[`DMC_AC_TIMER_B_PRESCALE];
  wire       shift_mode_rate  = aux_control[`DMC_AC_SHIFT_MODE_RATE];
  wire       baud_gen_run     = aux_control[`DMC_AC_BAUD_GEN_RUN];
  wire       baud_gen_prescale = aux_control[`DMC_AC_BAUD_GEN_PRESCALE];
  wire       serial_baud_source = aux_control[`DMC_AC_SERIAL_BAUD_SRC];
  wire [1:0] latch_stretch  = external_bus_stretch[`DMC_BS_LATCH_MSB:`DMC_BS_LATCH_LSB];
  wire [2:0] strobe_stretch = external_bus_stretch[`DMC_BS_STROBE_MSB:`DMC_BS_STROBE_LSB];
  wire       bank_select_hi = status_hold[`DMC_SW_BANK_HI];
  wire       bank_select_lo = status_hold[`DMC_SW_BANK_LO];

  // Parity is live from the accumulator, never stored
  wire       parity_flag = ^acc_value;
  wire [7:0] program_status_word = {status_hold[7:1], parity_flag};

  // Active pointer: both sit behind the same two addresses
  assign data_pointer = pointer_select ? pointer_one : pointer_zero;
  wire [15:0] ptr_write_value = hit_ptr_lo ? {data_pointer[15:8], sfr_wdata}
                                           : {sfr_wdata, data_pointer[7:0]};
  wire        ptr_write = sfr_wr_en && (hit_ptr_lo || hit_ptr_hi);
  wire [15:0] ptr_next  = ptr_write ? ptr_write_value : data_pointer + 16'h0001;

  // Working register address inside the lowest 32 bytes
  assign bank_addr = {3'b000, bank_select_hi, bank_select_lo, reg_index};

  // Register read mux; unmapped addresses and reserved bits read zero
  wire [7:0] read_mux = hit_aux     ? aux_control :
                        hit_aux_two ? aux_control_two :
                        hit_stretch ? external_bus_stretch :
                        hit_status  ? program_status_word :
                        hit_ptr_lo  ? data_pointer[7:0] :
                        hit_ptr_hi  ? data_pointer[15:8] : 8'h00;

  // Control register writes; masks keep reserved bits at zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aux_control          <= `DMC_RST_AUX_CONTROL;
      aux_control_two      <= `DMC_RST_AUX_CONTROL_TWO;
      external_bus_stretch <= `DMC_RST_BUS_STRETCH;
    end else if (sfr_wr_en) begin
      if (hit_aux) begin
        aux_control <= sfr_wdata & `DMC_MASK_AUX_CONTROL;
      end
      if (hit_aux_two) begin
        aux_control_two <= sfr_wdata & `DMC_MASK_AUX_CONTROL_TWO;
      end
      if (hit_stretch) begin
        external_bus_stretch <= sfr_wdata & `DMC_MASK_BUS_STRETCH;
      end
    end
  end

  // Status word: core flag updates first, a software write on the same edge overrides
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_hold <= `DMC_RST_STATUS_WORD;
    end else if (sfr_wr_en && hit_status) begin
      status_hold <= sfr_wdata & `DMC_MASK_STATUS_WORD;
    end else if (flag_wr_en) begin
      status_hold[`DMC_SW_CARRY]      <= carry_in;
      status_hold[`DMC_SW_HALF_CARRY] <= half_carry_in;
      status_hold[`DMC_SW_OVERFLOW]   <= overflow_in;
    end
  end

  // Only the selected pointer moves on a write or an increment
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pointer_zero <= 16'h0000;
      pointer_one  <= 16'h0000;
    end else if (ptr_write || ptr_inc) begin
      if (pointer_select) begin
        pointer_one <= ptr_next;
      end else begin
        pointer_zero <= ptr_next;
      end
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd_en) begin
      sfr_rdata <= read_mux;
    end
  end

  // Shared divider: div_count gives the /12 enable and a separate div_phase bit the /2 enable
  wire div_wrap = div_count == 4'(`DMC_CLK_DIV_SLOW - 1);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_count <= 4'h0;
      div_phase <= 1'b0;
    end else begin
      div_count <= div_wrap ? 4'h0 : div_count + 4'h1;
      div_phase <= div_phase + 1'b1;
    end
  end
  wire tick_slow  = div_wrap;
  wire tick_shift = div_phase == 1'(`DMC_CLK_DIV_SHIFT - 1);

  // Clock enables handed to timers, shift mode and baud generator
  assign timer_a_tick  = pick_rate(timer_a_prescale, 1'b1, tick_slow);
  assign timer_b_tick  = pick_rate(timer_b_prescale, 1'b1, tick_slow);
  assign shift_tick    = pick_rate(shift_mode_rate, tick_shift, tick_slow);
  assign baud_gen_tick = baud_gen_run
                       & pick_rate(baud_gen_prescale, 1'b1, tick_slow);
  assign serial_rate_tick = serial_baud_source ? baud_gen_tick
                                               : timer_b_overflow;
  assign serial_pin_relocate = aux_control_two[`DMC_AC2_SERIAL_PIN_RELOC];

  // Access address: byte-indirect uses zero page when aux RAM is on, page latch otherwise
  wire [15:0] req_addr = !xuse_ri       ? data_pointer :
                         !aux_ram_disable ? {8'h00, xri_addr}
                                          : {xpage_hi, xri_addr};
  wire req_internal = !aux_ram_disable && (req_addr <= `DMC_AUX_RAM_TOP);
  wire req_take     = xreq && state == ST_IDLE;

  // Auxiliary RAM is driven straight from the request, so it answers next cycle
  assign ram.addr  = req_addr[RAM_AW-1:0];
  assign ram.wdata = xwdata;
  assign ram.wr_en = req_take && req_internal && xwrite;
  assign ram.rd_en = req_take && req_internal && !xwrite;

  // Handshake
  assign xready = state == ST_IDLE;
  assign xack   = state == ST_INT_WAIT || state == ST_FINISH;
  assign xrdata = last_internal ? ram.rdata : ext_rdata;

  // Sequencer next state; each stretch phase lasts its count plus one
  always_comb begin
    next_state         = state;
    next_stretch_count = stretch_count;
    unique case (state)
      ST_IDLE: begin
        if (req_take && req_internal) begin
          next_state = ST_INT_WAIT;
        end else if (req_take) begin
          next_state         = ST_SETUP;
          next_stretch_count = {1'b0, latch_stretch};
        end
      end
      ST_INT_WAIT: begin
        next_state = ST_IDLE;
      end
      ST_SETUP: begin
        if (stretch_count == 3'h0) begin
          next_state         = ST_HOLD;
          next_stretch_count = {1'b0, latch_stretch};
        end else begin
          next_stretch_count = stretch_count - 3'h1;
        end
      end
      ST_HOLD: begin
        if (stretch_count == 3'h0) begin
          next_state         = ST_STROBE;
          next_stretch_count = strobe_stretch;
        end else begin
          next_stretch_count = stretch_count - 3'h1;
        end
      end
      ST_STROBE: begin
        if (stretch_count == 3'h0) begin
          next_state = ST_FINISH;
        end else begin
          next_stretch_count = stretch_count - 3'h1;
        end
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Pin values for the coming cycle, registered below to keep the strobes glitch free
  wire next_drive_addr = next_state == ST_SETUP || next_state == ST_HOLD;
  wire next_strobe     = next_state == ST_STROBE;
  wire next_latch      = next_state == ST_SETUP;
  wire xfer_write_next = req_take ? xwrite : xfer_write;
  wire next_wr_n       = !(next_strobe && xfer_write_next);
  wire next_rd_n       = !(next_strobe && !xfer_write_next);
  wire [15:0] xfer_addr_next  = req_take ? req_addr : xfer_addr;
  wire [7:0]  xfer_wdata_next = req_take ? xwdata : xfer_wdata;
  wire next_drive_data = next_strobe && xfer_write_next;
  wire [7:0] next_ad_out = next_drive_addr ? xfer_addr_next[7:0] :
                           next_drive_data ? xfer_wdata_next : 8'h00;

  // Sequencer and captured request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state         <= ST_IDLE;
      stretch_count <= 3'h0;
      xfer_addr     <= 16'h0000;
      xfer_write    <= 1'b0;
      xfer_wdata    <= 8'h00;
      last_internal <= 1'b0;
    end else begin
      state         <= next_state;
      stretch_count <= next_stretch_count;
      xfer_addr     <= xfer_addr_next;
      xfer_write    <= xfer_write_next;
      xfer_wdata    <= xfer_wdata_next;
      if (req_take) begin
        last_internal <= req_internal;
      end
    end
  end

  // External pins; read data caught on the last strobe cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_addr_hi <= 8'h00;
      ext_ad_out  <= 8'h00;
      ext_ad_oe_n <= 1'b1;
      ext_latch   <= 1'b0;
      ext_wr_n    <= 1'b1;
      ext_rd_n    <= 1'b1;
      ext_rdata   <= 8'h00;
    end else begin
      ext_addr_hi <= xfer_addr_next[15:8];
      ext_ad_out  <= next_ad_out;
      ext_ad_oe_n <= !(next_drive_addr || next_drive_data);
      ext_latch   <= next_latch;
      ext_wr_n    <= next_wr_n;
      ext_rd_n    <= next_rd_n;
      if (state == ST_STROBE && stretch_count == 3'h0 && !xfer_write) begin
        ext_rdata <= ext_ad_in;
      end
    end
  end

endmodule
`default_nettype wire

/* File: dmc_defines.svh */
// Purpose: Offsets, field positions, reset values and counts of the data memory control block
// Assumes: Registers sit in the direct special-function address space, 8 bits wide
// Notes:   Definitions only
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

// Register addresses in the direct address space
`define DMC_ADDR_AUX_CONTROL     8'h8e
`define DMC_ADDR_BUS_STRETCH     8'ha1
`define DMC_ADDR_AUX_CONTROL_TWO 8'ha2
`define DMC_ADDR_STATUS_WORD     8'hd0
`define DMC_ADDR_PTR_LOW         8'h82
`define DMC_ADDR_PTR_HIGH        8'h83

// Reset values
`define DMC_RST_AUX_CONTROL      8'h00
`define DMC_RST_AUX_CONTROL_TWO  8'h00
`define DMC_RST_STATUS_WORD      8'h00
`define DMC_RST_BUS_STRETCH      8'h23

// Writable bit masks; the rest is reserved and reads zero, except status word bit 0, which reads parity
`define DMC_MASK_AUX_CONTROL     8'hf7
`define DMC_MASK_AUX_CONTROL_TWO 8'h89
`define DMC_MASK_BUS_STRETCH     8'h37
`define DMC_MASK_STATUS_WORD     8'hfe

// Status word fields
`define DMC_SW_CARRY             7
`define DMC_SW_HALF_CARRY        6
`define DMC_SW_USER_A            5
`define DMC_SW_BANK_HI           4
`define DMC_SW_BANK_LO           3
`define DMC_SW_OVERFLOW          2
`define DMC_SW_USER_B            1
`define DMC_SW_PARITY            0

// Auxiliary control fields
`define DMC_AC_TIMER_A_PRESCALE  7
`define DMC_AC_TIMER_B_PRESCALE  6
`define DMC_AC_SHIFT_MODE_RATE   5
`define DMC_AC_BAUD_GEN_RUN      4
`define DMC_AC_BAUD_GEN_PRESCALE 2
`define DMC_AC_AUX_RAM_DISABLE   1
`define DMC_AC_SERIAL_BAUD_SRC   0

// Auxiliary control two fields
`define DMC_AC2_SERIAL_PIN_RELOC 7
`define DMC_AC2_GENERAL_FLAG     3
`define DMC_AC2_POINTER_SELECT   0

// Bus stretch fields
`define DMC_BS_LATCH_MSB         5
`define DMC_BS_LATCH_LSB         4
`define DMC_BS_STROBE_MSB        2
`define DMC_BS_STROBE_LSB        0

// Memory map and clock division
`define DMC_AUX_RAM_TOP          16'h03ff
`define DMC_CLK_DIV_SLOW         12
`define DMC_CLK_DIV_SHIFT        2

`endif

/* File: dmc_ext_ram_model.sv */
// Purpose: External data RAM on the multiplexed bus
// Assumes: Low address taken while the latch is high, data written during the write strobe
// Notes:   slow sets clocks of strobe before read data is valid; released bus toggles
`timescale 1ns/100ps
`default_nettype none
module dmc_ext_ram_model (
  // Clock
  input wire logic       ref_clk,
  // Bus from the device
  input wire logic [7:0] ext_addr_hi,
  input wire logic [7:0] ext_ad_out,
  input wire logic       ext_ad_oe_n,
  input wire logic       ext_latch,
  input wire logic       ext_wr_n,
  input wire logic       ext_rd_n,
  // Access time in clocks
  input wire logic [3:0] slow,
  // Data back to the device
  output logic     [7:0] ext_ad_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lo_addr = 8'h00;
  logic [3:0] rd_cnt  = 4'h0;
  logic [7:0] last    = 8'h5a;
  // Not yet valid or not reading: inverse of last value, so stale data never matches
  wire [15:0] addr  = {ext_addr_hi, lo_addr};
  wire        ready = !ext_rd_n && rd_cnt >= slow;
  assign ext_ad_in = ready ? mem[addr] : ~last;
  // Address latch, write capture and access timer
  always @(posedge ref_clk) begin
    if (ext_latch && !ext_ad_oe_n) lo_addr <= ext_ad_out;
    if (!ext_wr_n && !ext_ad_oe_n) mem[addr] <= ext_ad_out;
    rd_cnt <= ext_rd_n ? 4'h0 : rd_cnt + 4'h1;
    last <= ext_ad_in;
  end
endmodule
`default_nettype wire

/* File: dmc_memctl_sva.sv */
// Purpose: Port-level assertions for the data memory control block
// Assumes: Field copies below track register writes made through the register port
// Notes:   Bound to the top module after endmodule
`timescale 1ns/100ps
`default_nettype none
module dmc_memctl_sva (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr_en,
  input wire logic        sfr_rd_en,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Banks, pointer and access
  input wire logic [2:0]  reg_index,
  input wire logic [7:0]  bank_addr,
  input wire logic [15:0] data_pointer,
  input wire logic        xreq,
  input wire logic        xuse_ri,
  input wire logic        xready,
  input wire logic        xack,
  // External bus
  input wire logic        ext_latch,
  input wire logic        ext_wr_n,
  input wire logic        ext_rd_n,
  // Rate enables
  input wire logic        timer_b_overflow,
  input wire logic        baud_gen_tick,
  input wire logic        serial_rate_tick
);
  logic [7:0] aux;
  logic [7:0] stretch;
  logic [3:0] low_cnt;
  logic [3:0] latch_cnt;
  // Decode; byte-indirect accesses land on chip while the RAM is enabled
  wire strobe_low = !ext_rd_n || !ext_wr_n;
  wire taken      = xreq && xready;
  wire internal   = !aux[1] && (xuse_ri || data_pointer <= 16'h03ff);
  wire unmapped   = !(sfr_addr inside {8'h8e, 8'ha1, 8'ha2, 8'hd0, 8'h82, 8'h83});
  // Field copies, since the registers themselves are not visible here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aux     <= 8'h00;
      stretch <= 8'h23;
    end else if (sfr_wr_en && sfr_addr == 8'h8e) begin
      aux <= sfr_wdata;
    end else if (sfr_wr_en && sfr_addr == 8'ha1) begin
      stretch <= sfr_wdata;
    end
  end
  // Length of the current strobe and latch pulses
  always_ff @(posedge ref_clk) begin
    low_cnt   <= (reset || !strobe_low) ? 4'h0 : low_cnt + 4'h1;
    latch_cnt <= (reset || !ext_latch) ? 4'h0 : latch_cnt + 4'h1;
  end
  default clocking dmc_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_bank_index;
    bank_addr[7:5] == 3'h0 && bank_addr[2:0] == reg_index;
  endproperty
  a_bank_index: assert property (p_bank_index) else $error("bank address wrong");
  property p_bank_write;
    logic [1:0] sel;
    (sfr_wr_en && sfr_addr == 8'hd0, sel = sfr_wdata[4:3]) |=> bank_addr[4:3] == sel;
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank select not written");
  property p_unmapped;
    sfr_rd_en && unmapped |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_internal;
    taken && internal |=> xack && ext_rd_n && ext_wr_n && !ext_latch;
  endproperty
  a_internal: assert property (p_internal) else $error("on-chip access slow or on bus");
  property p_external;
    taken && !internal |=> ext_latch && !xack;
  endproperty
  a_external: assert property (p_external) else $error("bus access not started");
  property p_strobe;
    $fell(strobe_low) |-> low_cnt == {1'b0, stretch[2:0]} + 4'h1;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width wrong");
  property p_latch;
    $fell(ext_latch) |-> latch_cnt == {2'b00, stretch[5:4]} + 4'h1;
  endproperty
  a_latch: assert property (p_latch) else $error("latch width wrong");
  property p_rate_source;
    serial_rate_tick == (aux[0] ? baud_gen_tick : timer_b_overflow);
  endproperty
  a_rate_source: assert property (p_rate_source) else $error("serial rate source wrong");
endmodule
bind dmc_data_memory_control dmc_memctl_sva u_sva (
  .ref_clk, .reset, .sfr_addr, .sfr_wr_en, .sfr_rd_en, .sfr_wdata, .sfr_rdata, .reg_index, .bank_addr,
  .data_pointer, .xreq, .xuse_ri, .xready, .xack, .ext_latch, .ext_wr_n, .ext_rd_n,
  .timer_b_overflow, .baud_gen_tick, .serial_rate_tick
);
`default_nettype wire

/* File: dmc_pkg.sv */
// Purpose: Types shared by the data memory control block
// Assumes: Constants live in dmc_defines.svh
// Notes:   Types only
package dmc_pkg;

  // External and internal access sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INT_WAIT,
    ST_SETUP,
    ST_HOLD,
    ST_STROBE,
    ST_FINISH
  } dmc_state_type;

endpackage

/* File: dmc_ram_if.sv */
// Purpose: Port bundle between the access sequencer and the auxiliary RAM
// Assumes: Single clock, registered read data
// Notes:   ctrl drives requests, mem answers
`timescale 1ns/100ps
`default_nettype none
interface dmc_ram_if #(parameter int ADDR_W = 10);
  logic [ADDR_W-1:0] addr;
  logic              wr_en;
  logic              rd_en;
  logic [7:0]        wdata;
  logic [7:0]        rdata;

  modport ctrl (output addr, output wr_en, output rd_en, output wdata, input rdata);
  modport mem  (input addr, input wr_en, input rd_en, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the data memory control block
// Assumes: Inputs change 1 ns after the rising edge; external RAM model on the bus
// Notes:   Register rows first, then pointer, bank, rate, access and reset cases
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} dmc_row_type;
  // Write then read back; reserved bits must come back zero
  localparam dmc_row_type ROWS [9] = '{
    '{8'h8e, 8'hff, 8'hf7}, '{8'ha2, 8'hff, 8'h89}, '{8'ha1, 8'hff, 8'h37},
    '{8'hd0, 8'hff, 8'hfe}, '{8'hd0, 8'h18, 8'h18}, '{8'h55, 8'hab, 8'h00},
    '{8'ha1, 8'h00, 8'h00}, '{8'h8e, 8'h00, 8'h00}, '{8'ha2, 8'h00, 8'h00}};
  logic        ref_clk = 1'b0, reset = 1'b1, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, flag_wr_en = 1'b0;
  logic        carry_in = 1'b0, half_carry_in = 1'b0, overflow_in = 1'b0, ptr_inc = 1'b0, xreq = 1'b0;
  logic        xwrite = 1'b0, xuse_ri = 1'b0, timer_b_overflow = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, acc_value = 8'h00, xri_addr = 8'h00;
  logic [7:0]  xpage_hi = 8'h00, xwdata = 8'h00;
  logic [2:0]  reg_index = 3'h5;
  logic [3:0]  slow = 4'h0;
  logic [7:0]  sfr_rdata, bank_addr, xrdata, ext_addr_hi, ext_ad_in, ext_ad_out;
  logic [15:0] data_pointer;
  logic        xready, xack, ext_ad_oe_n, ext_latch, ext_wr_n, ext_rd_n, timer_a_tick, timer_b_tick;
  logic        shift_tick, baud_gen_tick, serial_rate_tick, serial_pin_relocate;
  int          mismatches = 0, check_count = 0;
  dmc_data_memory_control dut (
    .ref_clk, .reset, .sfr_addr, .sfr_wr_en, .sfr_rd_en, .sfr_wdata, .sfr_rdata, .flag_wr_en, .carry_in,
    .half_carry_in, .overflow_in, .acc_value, .ptr_inc, .reg_index, .bank_addr, .data_pointer, .xreq,
    .xwrite, .xuse_ri, .xri_addr, .xpage_hi, .xwdata, .xready, .xack, .xrdata, .ext_addr_hi, .ext_ad_in,
    .ext_ad_out, .ext_ad_oe_n, .ext_latch, .ext_wr_n, .ext_rd_n, .timer_b_overflow, .timer_a_tick,
    .timer_b_tick, .shift_tick, .baud_gen_tick, .serial_rate_tick, .serial_pin_relocate);
  dmc_ext_ram_model ext_ram (.ref_clk, .ext_addr_hi, .ext_ad_out, .ext_ad_oe_n, .ext_latch, .ext_wr_n,
    .ext_rd_n, .slow, .ext_ad_in);
  // 50 MHz clock
  initial forever #10 ref_clk = ~ref_clk;
  task automatic final_report;
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  // Register port: one-cycle strobe, then an idle cycle so strobes never merge
  task automatic sfr_write(input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    step();
    sfr_wr_en = 1'b0;
    step();
  endtask
  task automatic sfr_read(input logic [7:0] a, exp);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    step();
    sfr_rd_en = 1'b0;
    check(sfr_rdata, exp);
    step();
  endtask
  // Request held until taken; cycles counted from the taking edge to completion
  task automatic xfer(input logic wr, ri, input logic [7:0] d, exp_d, input int exp_n);
    logic [7:0] n;
    xwrite = wr;
    xuse_ri = ri;
    xwdata = d;
    xreq = 1'b1;
    n = 8'h00;
    while (xready !== 1'b1 && n < 8'd100) begin
      n++;
      step();
    end
    step();
    xreq = 1'b0;
    n = 8'h01;
    while (xack !== 1'b1 && n < 8'd100) begin
      step();
      n++;
    end
    check(n, exp_n);
    if (!wr) check(xrdata, exp_d);
    step();
  endtask
  // Counts each rate enable over 24 settled cycles
  task automatic rates(input logic [7:0] aux, input int ta, tb, sh, bg, sr);
    logic [7:0] n [5];
    n = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    sfr_write(8'h8e, aux);
    repeat (12) step();
    repeat (24) begin
      n[0] += timer_a_tick;
      n[1] += timer_b_tick;
      n[2] += shift_tick;
      n[3] += baud_gen_tick;
      n[4] += serial_rate_tick;
      step();
    end
    check(n[0], ta);
    check(n[1], tb);
    check(n[2], sh);
    check(n[3], bg);
    check(n[4], sr);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 reset = 1'b0;
    foreach (ROWS[i]) begin
      sfr_write(ROWS[i].addr, ROWS[i].wdata);
      sfr_read(ROWS[i].addr, ROWS[i].exp);
    end
    sfr_write(8'ha2, 8'h80);
    check(serial_pin_relocate, 1'b1);
    // Two pointers behind one address pair
    sfr_write(8'h82, 8'h34);
    sfr_write(8'h83, 8'h12);
    sfr_write(8'ha2, 8'h01);
    check(data_pointer, 16'h0000);
    sfr_write(8'h82, 8'hcd);
    sfr_write(8'h83, 8'hab);
    sfr_read(8'h83, 8'hab);
    sfr_write(8'ha2, 8'h00);
    ptr_inc = 1'b1;
    step();
    ptr_inc = 1'b0;
    step();
    check(data_pointer, 16'h1235);
    sfr_write(8'ha2, 8'h01);
    check(data_pointer, 16'habcd);
    sfr_write(8'ha2, 8'h00);
    for (int b = 0; b < 4; b++) begin
      sfr_write(8'hd0, 8'(b << 3));
      check(bank_addr, {3'h0, 2'(b), 3'h5});
    end
    // Core flag load beside user flags; parity follows the accumulator
    sfr_write(8'hd0, 8'h22);
    acc_value = 8'h07;
    carry_in = 1'b1;
    overflow_in = 1'b1;
    flag_wr_en = 1'b1;
    step();
    flag_wr_en = 1'b0;
    step();
    sfr_read(8'hd0, 8'ha7);
    acc_value = 8'h00;
    timer_b_overflow = 1'b1;
    rates(8'h00, 2, 2, 2, 0, 24);
    rates(8'hf5, 24, 24, 12, 24, 24);
    rates(8'h11, 2, 2, 2, 2, 2);
    timer_b_overflow = 1'b0;
    // On-chip top byte with maximum stretch set, then a slow device past it
    sfr_write(8'ha1, 8'h37);
    sfr_write(8'h82, 8'hff);
    sfr_write(8'h83, 8'h03);
    xfer(1'b1, 1'b0, 8'h5a, 8'h00, 1);
    xfer(1'b0, 1'b0, 8'h00, 8'h5a, 1);
    sfr_write(8'h82, 8'h00);
    sfr_write(8'h83, 8'h04);
    slow = 4'h6;
    xfer(1'b1, 1'b0, 8'hc3, 8'h00, 17);
    xfer(1'b0, 1'b0, 8'h00, 8'hc3, 17);
    slow = 4'h0;
    sfr_write(8'ha1, 8'h00);
    xfer(1'b0, 1'b0, 8'h00, 8'hc3, 4);
    xri_addr = 8'h10;
    xpage_hi = 8'hff;
    xfer(1'b1, 1'b1, 8'h96, 8'h00, 1);
    xfer(1'b0, 1'b1, 8'h00, 8'h96, 1);
    sfr_write(8'h8e, 8'h02);
    xri_addr = 8'h00;
    xpage_hi = 8'h04;
    xfer(1'b0, 1'b1, 8'h00, 8'hc3, 4);
    sfr_write(8'h82, 8'hff);
    sfr_write(8'h83, 8'h03);
    xfer(1'b1, 1'b0, 8'h3c, 8'h00, 4);
    xfer(1'b0, 1'b0, 8'h00, 8'h3c, 4);
    sfr_write(8'h8e, 8'h00);
    xfer(1'b0, 1'b0, 8'h00, 8'h5a, 1);
    // Reset in mid-run restores defaults
    reset = 1'b1;
    step();
    step();
    reset = 1'b0;
    sfr_read(8'ha1, 8'h23);
    sfr_read(8'ha2, 8'h00);
    check(data_pointer, 16'h0000);
    final_report();
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
